// *** logic/frlp_defines.svh ***
// Constants of the flash row latch programmer: sizes, keys, reset values.
// Assumes inclusion by the package and by every design file that needs it.
`ifndef FRLP_DEFINES_SVH
`define FRLP_DEFINES_SVH

// Latch bank shape: one row of words
`define FRLP_LATCH_WORDS   32
`define FRLP_WORD_WIDTH    14
`define FRLP_INDEX_WIDTH   5

// Blank value of an unprogrammed word
`define FRLP_BLANK_WORD    14'h3fff

// Word address layout: row in the upper ten bits, latch index below
`define FRLP_ADDR_WIDTH    15
`define FRLP_ROW_MSB       14
`define FRLP_ROW_LSB       5
`define FRLP_INDEX_MSB     4
`define FRLP_HIGH_WIDTH    7
`define FRLP_LOW_WIDTH     8
`define FRLP_DATA_HIGH_W   6

// Unlock keys, written in this order to the key register
`define FRLP_KEY_FIRST     8'h55
`define FRLP_KEY_SECOND    8'haa

// Top word of user flash while the configuration space is deselected
`define FRLP_USER_TOP      15'h17ff

`endif

// *** logic/frlp_pkg.sv ***
// Types of the flash row latch programmer: sequencer states, array commands.
// Assumes the defines header is on the include path.
`include "frlp_defines.svh"

package frlp_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    FRLP_IDLE    = 3'b000,
    FRLP_KEY_ONE = 3'b001,
    FRLP_ARMED   = 3'b010,
    FRLP_LATCH   = 3'b011,
    FRLP_PROG    = 3'b100,
    FRLP_ERASE   = 3'b101,
    FRLP_READ    = 3'b110
  } frlp_state_type;

  // Commands offered to the flash array
  typedef enum logic [1:0] {
    FRLP_CMD_READ    = 2'b00,
    FRLP_CMD_PROGRAM = 2'b01,
    FRLP_CMD_ERASE   = 2'b10
  } frlp_cmd_type;

endpackage : frlp_pkg

// *** logic/frlp_latch_bank.sv ***
// Bank of word write latches covering one flash row.
// Assumes one clock and a synchronous active-low reset; load and clear are
// single-cycle pulses from the sequencer.
`timescale 1ns/10ps
`include "frlp_defines.svh"

module frlp_latch_bank #(
  parameter int          WORDS   = `FRLP_LATCH_WORDS,
  parameter int          WIDTH   = `FRLP_WORD_WIDTH,
  parameter int          IDX_W   = `FRLP_INDEX_WIDTH,
  parameter [WIDTH-1:0]  BLANK   = `FRLP_BLANK_WORD
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             clear_i,
  input  wire logic             load_i,
  input  wire logic [IDX_W-1:0] load_idx_i,
  input  wire logic [WIDTH-1:0] load_data_i,
  input  wire logic [IDX_W-1:0] rd_idx_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] latch [WORDS];

  // Latch storage: blank after reset and after every completed program or erase
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || clear_i)
    begin
      for (int i = 0; i < WORDS; i++)
      begin
        latch[i] <= BLANK;                    // [RULE6] [RULE7]
      end
    end
    else if (load_i)
    begin
      latch[load_idx_i] <= load_data_i;       // [RULE8]
    end
  end

  // Word picked for the array by the sequencer's index
  assign rd_data_o = latch[rd_idx_i];

endmodule : frlp_latch_bank

// *** logic/frlp_top.sv ***
// Flash row latch programmer: unlock check, latch loading, row commit,
// row erase and word read toward the program flash array.
// Assumes the core drives every input from the same clock, and that the
// array takes one command per valid/ready handshake and pulses done.
//
// Summary of operation
// RULE1 - Software programs only erased words; commit never erases first.
// RULE2 - Erase always acts on a whole row, never on a smaller unit.
// RULE3 - One commit writes at most the 32 latches of one row.
// RULE4 - Row is address bits 14:5; bits 4:0 pick the latch.
// RULE5 - Loads and commits stay inside the addressed row.
// RULE6 - Every completed program or erase returns all latches to 3fff.
// RULE7 - Unloaded latches stay blank and are programmed blank.
// RULE8 - Latch-only set: unlocked start copies the data pair into a latch.
// RULE9 - Latch-only clear: unlocked start programs the whole latch bank.
// RULE10 - Loads and commits need the full unlock; broken sequences do nothing. Here a broken sequence also sets the error flag.
// RULE11 - Software enables, picks flash, sets latch-only, loads each word.
// RULE12 - Software clears latch-only and unlocks once more to commit.
// RULE13 - Flash space 0000 to 17ff is readable and writable.
// RULE14 - Unlock order is 55, then aa, then start, uninterrupted.
// RULE15 - Protected commit or erase clears start, sets error, no change.
// RULE16 - Latch loads ignore protection and never touch the array.
// RULE17 - The core stalls from start until the operation completes.
// RULE18 - Hardware clears the start bit when a load or commit completes.
`timescale 1ns/10ps
`include "frlp_defines.svh"

module frlp_top (
  input  wire logic                          clock_i,
  input  wire logic                          rst_n_i,
  // Control bits from the core
  input  wire logic                          program_enable_i,
  input  wire logic                          latch_only_load_i,
  input  wire logic                          config_space_select_i,
  input  wire logic                          erase_select_i,
  input  wire logic                          start_i,
  input  wire logic                          read_start_i,
  input  wire logic                          seq_break_i,
  input  wire logic                          error_set_i,
  input  wire logic                          error_clear_i,
  // Unlock key register write
  input  wire logic                          key_wr_i,
  input  wire logic [7:0]                    key_data_i,
  // Address and data register pairs
  input  wire logic [`FRLP_HIGH_WIDTH-1:0]   flash_address_high_i,
  input  wire logic [`FRLP_LOW_WIDTH-1:0]    flash_address_low_i,
  input  wire logic [`FRLP_DATA_HIGH_W-1:0]  flash_data_high_i,
  input  wire logic [`FRLP_LOW_WIDTH-1:0]    flash_data_low_i,
  input  wire logic                          write_protected_i,
  // Status toward the core
  output logic                               start_busy_o,
  output logic                               stall_o,
  output logic                               program_error_flag_o,
  output logic      [`FRLP_WORD_WIDTH-1:0]   read_data_o,
  // Flash array side
  output logic                               flash_cmd_valid_o,
  input  wire logic                          flash_cmd_ready_i,
  output frlp_pkg::frlp_cmd_type             flash_cmd_o,
  output logic      [`FRLP_ADDR_WIDTH-1:0]   flash_addr_o,
  output logic      [`FRLP_WORD_WIDTH-1:0]   flash_wdata_o,
  input  wire logic                          flash_done_i,
  input  wire logic [`FRLP_WORD_WIDTH-1:0]   flash_rdata_i
);

  import frlp_pkg::*;

  localparam logic [`FRLP_INDEX_WIDTH-1:0] LAST_IDX =
    `FRLP_INDEX_WIDTH'(`FRLP_LATCH_WORDS - 1);

  frlp_state_type                   state;
  logic                             cmd_wait;
  logic [`FRLP_ADDR_WIDTH-1:0]      op_addr;
  logic [`FRLP_ADDR_WIDTH-1:0]      full_addr;
  logic [`FRLP_WORD_WIDTH-1:0]      data_pair;
  logic                             key_first;
  logic                             key_second;
  logic                             target_ok;
  logic                             go;
  logic                             go_latch;
  logic                             go_array;
  logic                             go_refused;
  logic                             seq_broken;
  logic                             cmd_fire;
  logic                             op_last;
  logic                             clear_latches;
  logic                             read_ok;

  // Register pairs joined into word address and word data
  assign full_addr = {flash_address_high_i, flash_address_low_i};   // [RULE4]
  assign data_pair = {flash_data_high_i, flash_data_low_i};

  // Unlock key recognition
  assign key_first  = key_wr_i && (key_data_i == `FRLP_KEY_FIRST);
  assign key_second = key_wr_i && (key_data_i == `FRLP_KEY_SECOND);

  // Only user flash up to and including the top word is a target for array access
  assign target_ok = !config_space_select_i
                  && (full_addr <= `FRLP_USER_TOP);                  // [RULE13]
  assign read_ok   = target_ok;

  // Start taken only after both keys, with writes enabled
  assign go         = (state == FRLP_ARMED) && start_i && program_enable_i
                   && !seq_break_i && !key_wr_i;                    // [RULE10]
  assign go_latch   = go && latch_only_load_i && !erase_select_i;   // [RULE16]
  assign go_array   = go && !go_latch && target_ok
                   && !write_protected_i;                           // [RULE15]
  assign go_refused = go && !go_latch && !go_array;                 // [RULE15]

  // Sequence broken: stray event between the steps, or start too early
  assign seq_broken =
      ((state == FRLP_KEY_ONE)
        && (seq_break_i || start_i || (key_wr_i && !key_second)))
   || ((state == FRLP_ARMED) && (seq_break_i || key_wr_i))
   || ((state == FRLP_IDLE) && start_i && program_enable_i);        // [RULE14]

  // Array handshake and end of the current array operation
  assign cmd_fire = flash_cmd_valid_o && flash_cmd_ready_i;
  assign op_last  = cmd_wait && flash_done_i
                 && ((state != FRLP_PROG)
                     || (op_addr[`FRLP_INDEX_MSB:0] == LAST_IDX));  // [RULE3]
  assign clear_latches = op_last
                      && ((state == FRLP_PROG) || (state == FRLP_ERASE));

  // Sequencer state
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state <= FRLP_IDLE;
    end
    else
    begin
      unique case (state)
        FRLP_IDLE:
        begin
          if (read_start_i && read_ok)
          begin
            state <= FRLP_READ;
          end
          else if (key_first && !seq_break_i && !start_i)
          begin
            state <= FRLP_KEY_ONE;                                  // [RULE14]
          end
        end
        FRLP_KEY_ONE:
        begin
          if (seq_broken)
          begin
            state <= FRLP_IDLE;                                     // [RULE10]
          end
          else if (key_second)
          begin
            state <= FRLP_ARMED;                                    // [RULE14]
          end
        end
        FRLP_ARMED:
        begin
          if (go_latch)
          begin
            state <= FRLP_LATCH;                                    // [RULE8]
          end
          else if (go_array && erase_select_i)
          begin
            state <= FRLP_ERASE;                                    // [RULE2]
          end
          else if (go_array)
          begin
            state <= FRLP_PROG;                                     // [RULE9]
          end
          else if (seq_broken || go_refused)
          begin
            state <= FRLP_IDLE;                                     // [RULE10]
          end
        end
        FRLP_LATCH:
        begin
          state <= FRLP_IDLE;                                       // [RULE18]
        end
        FRLP_PROG, FRLP_ERASE, FRLP_READ:
        begin
          if (op_last)
          begin
            state <= FRLP_IDLE;                                     // [RULE18]
          end
        end
        default:
        begin
          state <= FRLP_IDLE;
        end
      endcase
    end
  end

  // One command outstanding at a time; wait for done before the next
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      cmd_wait <= 1'b0;
    end
    else if (cmd_fire)
    begin
      cmd_wait <= 1'b1;
    end
    else if (cmd_wait && flash_done_i)
    begin
      cmd_wait <= 1'b0;
    end
  end

  // Operation address: row fixed at start, index walks within the row
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      op_addr <= '0;
    end
    else if (go_array)
    begin
      op_addr <= {full_addr[`FRLP_ROW_MSB:`FRLP_ROW_LSB],
                  `FRLP_INDEX_WIDTH'(0)};                           // [RULE5]
    end
    else if ((state == FRLP_IDLE) && read_start_i)
    begin
      op_addr <= full_addr;
    end
    else if ((state == FRLP_PROG) && cmd_wait && flash_done_i && !op_last)
    begin
      // Only the index field counts, so the row can never change
      op_addr[`FRLP_INDEX_MSB:0] <=
        op_addr[`FRLP_INDEX_MSB:0] + 1'b1;                          // [RULE5]
    end
  end

  // Error flag: hardware and software set it, software clears it; set wins
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      program_error_flag_o <= 1'b0;
    end
    else if (seq_broken || go_refused || error_set_i)
    begin
      program_error_flag_o <= 1'b1;                                 // [RULE15]
    end
    else if (error_clear_i)
    begin
      program_error_flag_o <= 1'b0;
    end
  end

  // Read data: array word on done, zeros for an address outside user flash
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      read_data_o <= '0;
    end
    else if ((state == FRLP_IDLE) && read_start_i && !read_ok)
    begin
      read_data_o <= '0;
    end
    else if ((state == FRLP_READ) && cmd_wait && flash_done_i)
    begin
      read_data_o <= flash_rdata_i;                                 // [RULE13]
    end
  end

  // Start bit and stall follow the state register
  assign start_busy_o = (state == FRLP_LATCH) || (state == FRLP_PROG)
                     || (state == FRLP_ERASE);                      // [RULE18]
  assign stall_o      = start_busy_o || (state == FRLP_READ);       // [RULE17]

  // Array command channel; latch loads never raise it
  assign flash_cmd_valid_o = !cmd_wait
                          && ((state == FRLP_PROG) || (state == FRLP_ERASE)
                              || (state == FRLP_READ));             // [RULE16]
  assign flash_addr_o      = op_addr;
  always_comb
  begin
    unique case (state)
      FRLP_PROG:  flash_cmd_o = FRLP_CMD_PROGRAM;                   // [RULE9]
      FRLP_ERASE: flash_cmd_o = FRLP_CMD_ERASE;                     // [RULE2]
      default:    flash_cmd_o = FRLP_CMD_READ;
    endcase
  end

  // Write latches: a load start fills one word, and a commit start also
  // takes the last data word before the row is programmed
  frlp_latch_bank #(
    .WORDS (`FRLP_LATCH_WORDS),
    .WIDTH (`FRLP_WORD_WIDTH),
    .IDX_W (`FRLP_INDEX_WIDTH),
    .BLANK (`FRLP_BLANK_WORD)
  ) u_latch_bank (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .clear_i     (clear_latches),                                   // [RULE6]
    .load_i      (go_latch || (go_array && !erase_select_i)),    // [RULE8]
    .load_idx_i  (full_addr[`FRLP_INDEX_MSB:0]),                    // [RULE4]
    .load_data_i (data_pair),
    .rd_idx_i    (op_addr[`FRLP_INDEX_MSB:0]),
    .rd_data_o   (flash_wdata_o)                                    // [RULE7]
  );

endmodule : frlp_top

// *** bench/frlp_top_asserts.sv ***
// Port checker for the flash row latch programmer, bound into frlp_top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`include "frlp_defines.svh"
module frlp_top_asserts (
  input wire logic                        clock_i,
  input wire logic                        rst_n_i,
  input wire logic                        program_enable_i,
  input wire logic                        start_i,
  input wire logic [`FRLP_HIGH_WIDTH-1:0] flash_address_high_i,
  input wire logic [`FRLP_LOW_WIDTH-1:0]  flash_address_low_i,
  input wire logic                        start_busy_o,
  input wire logic                        stall_o,
  input wire logic                        program_error_flag_o,
  input wire logic                        flash_cmd_valid_o,
  input wire logic                        flash_cmd_ready_i,
  input wire frlp_pkg::frlp_cmd_type      flash_cmd_o,
  input wire logic [`FRLP_ADDR_WIDTH-1:0] flash_addr_o,
  input wire logic [`FRLP_WORD_WIDTH-1:0] flash_wdata_o
);
  import frlp_pkg::*;
  // One clock domain for every property
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_busy_stall: assert property (start_busy_o |-> stall_o)
    else $error("busy without stall");
  a_read_stall: assert property
    (stall_o && !start_busy_o |-> flash_cmd_o == FRLP_CMD_READ)
    else $error("stall without operation");
  a_start_cause: assert property
    ($rose(start_busy_o) |-> $past(start_i) && $past(program_enable_i))
    else $error("busy rose without start");
  a_hold_cmd: assert property
    (flash_cmd_valid_o && !flash_cmd_ready_i |=> flash_cmd_valid_o
     && $stable(flash_addr_o) && $stable(flash_wdata_o))
    else $error("command changed before accept");
  a_fire_wait: assert property
    (flash_cmd_valid_o && flash_cmd_ready_i |=> !flash_cmd_valid_o)
    else $error("command reissued before done");
  a_row_match: assert property
    (flash_cmd_valid_o && flash_cmd_o != FRLP_CMD_READ |-> flash_addr_o[14:5]
     == {flash_address_high_i, flash_address_low_i[7:5]})
    else $error("command left the addressed row");
  a_erase_base: assert property
    (flash_cmd_valid_o && flash_cmd_o == FRLP_CMD_ERASE
     |-> flash_addr_o[4:0] == 5'h00)
    else $error("erase not at row base");
  a_blank_after: assert property
    ($fell(start_busy_o) && $past(start_busy_o, 2)
     |-> flash_wdata_o == `FRLP_BLANK_WORD)
    else $error("latches not blank after operation");
  a_err_quiet: assert property
    ($rose(program_error_flag_o) |-> !start_busy_o ##1 !flash_cmd_valid_o)
    else $error("refused start reached the array");
endmodule : frlp_top_asserts

bind frlp_top frlp_top_asserts u_frlp_top_asserts (.clock_i, .rst_n_i,
  .program_enable_i, .start_i, .flash_address_high_i, .flash_address_low_i,
  .start_busy_o, .stall_o, .program_error_flag_o, .flash_cmd_valid_o,
  .flash_cmd_ready_i, .flash_cmd_o, .flash_addr_o, .flash_wdata_o);

// *** bench/frlp_flash_model.sv ***
// Behavioural program flash array on the far side of the sequencer.
// Assumes one clock; one command per valid/ready handshake, done pulses.
`timescale 1ns/10ps
module frlp_flash_model (
  input  wire logic                   clock_i,
  input  wire logic                   slow_i,
  input  wire logic                   valid_i,
  output logic                        ready_o,
  input  wire frlp_pkg::frlp_cmd_type cmd_i,
  input  wire logic [14:0]            addr_i,
  input  wire logic [13:0]            wdata_i,
  output logic                        done_o,
  output logic      [13:0]            rdata_o
);
  import frlp_pkg::*;
  logic [13:0] mem [0:32767];
  logic [13:0] rd;
  logic [2:0]  dly;
  logic        tog;
  // Erased array, idle channel
  initial
  begin
    for (int i = 0; i < 32768; i++) mem[i] = 14'h3fff;
    dly = 3'h0;
    tog = 1'b0;
    rd = 14'h0000;
    done_o = 1'b0;
  end
  // Slow mode refuses every other cycle and answers late
  assign ready_o = (dly == 3'h0) && (!slow_i || tog);
  // Stale read data is inverted outside the done pulse
  assign rdata_o = done_o ? rd : ~rd;
  // Command execution
  always @(posedge clock_i)
  begin
    tog <= ~tog;
    done_o <= (dly == 3'h1);
    if (dly != 3'h0) dly <= dly - 3'h1;
    if (valid_i && ready_o)
    begin
      dly <= slow_i ? 3'h4 : 3'h1;
      if (cmd_i == FRLP_CMD_PROGRAM)
        mem[addr_i] <= mem[addr_i] & wdata_i; // Clears bits only
      else if (cmd_i == FRLP_CMD_ERASE)
        for (int i = 0; i < 32; i++)
          mem[{addr_i[14:5], 5'(i)}] <= 14'h3fff; // Whole row
      else
        rd <= mem[addr_i];
    end
  end
endmodule : frlp_flash_model

// *** bench/tb.sv ***
// Self-checking bench: loads, commit, refusals, reads and erase.
// Assumes the design, flash model and checker are compiled before it.
`timescale 1ns/10ps
module tb;
  import frlp_pkg::*;
  logic clock_i, rst_n_i, en, lo, ers, st, rs, brk, eclr, kw, wp, slow, cfg;
  logic [7:0] kd, al, dl;
  logic [6:0] ah;
  logic [5:0] dh;
  logic busy, stall, err, vld, rdy, done;
  logic [13:0] rdat, wdat, frd;
  logic [14:0] fa;
  frlp_cmd_type cmd;
  int fails, n_tests, fires, cyc, f0;
  frlp_top u_frlp_top (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .program_enable_i(en), .latch_only_load_i(lo),
    .config_space_select_i(cfg), .erase_select_i(ers), .start_i(st),
    .read_start_i(rs), .seq_break_i(brk), .error_set_i(1'b0),
    .error_clear_i(eclr), .key_wr_i(kw), .key_data_i(kd),
    .flash_address_high_i(ah), .flash_address_low_i(al),
    .flash_data_high_i(dh), .flash_data_low_i(dl), .write_protected_i(wp),
    .start_busy_o(busy), .stall_o(stall), .program_error_flag_o(err),
    .read_data_o(rdat), .flash_cmd_valid_o(vld), .flash_cmd_ready_i(rdy),
    .flash_cmd_o(cmd), .flash_addr_o(fa), .flash_wdata_o(wdat),
    .flash_done_i(done), .flash_rdata_i(frd));
  frlp_flash_model u_frlp_flash_model (.clock_i(clock_i), .slow_i(slow),
    .valid_i(vld), .ready_o(rdy), .cmd_i(cmd), .addr_i(fa),
    .wdata_i(wdat), .done_o(done), .rdata_o(frd));
  // Clock, accepted-command count and hang guard
  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    if (vld === 1'b1 && rdy === 1'b1) fires++;
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      $display("ERROR %0t: cycle limit reached", $time);
      report_and_stop();
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task report_and_stop();
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // Waits until the core is released, bounded
  task wait_free();
    int n;
    n = 0;
    @(posedge clock_i);
    #1;
    while (stall !== 1'b0 && n < 1000)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (n == 1000)
    begin
      fails++;
      $display("ERROR %0t: core stall never released", $time);
    end
  endtask : wait_free
  task key(input logic [7:0] v);
    @(posedge clock_i);
    kw <= 1'b1;
    kd <= v;
    @(posedge clock_i);
    kw <= 1'b0;
  endtask : key
  task pulse_start();
    @(posedge clock_i);
    st <= 1'b1;
    @(posedge clock_i);
    st <= 1'b0;
    wait_free();
  endtask : pulse_start
  task unlock();
    key(8'h55);
    key(8'haa);
    pulse_start();
  endtask : unlock
  task set_ad(input logic [14:0] a, input logic [13:0] d);
    @(posedge clock_i);
    {ah, al} <= a;
    {dh, dl} <= d;
  endtask : set_ad
  task t_commit();
    @(posedge clock_i);
    slow <= 1'b1;
    en <= 1'b1;
    lo <= 1'b1;
    f0 = fires;
    set_ad(15'h0060, 14'h1234);
    unlock();
    set_ad(15'h0065, 14'h0abc);
    unlock();
    check(fires, f0);
    @(posedge clock_i);
    lo <= 1'b0;
    set_ad(15'h007f, 14'h0155);
    unlock();
    check(fires - f0, 32);
    check(u_frlp_flash_model.mem[15'h0060], 14'h1234);
    check(u_frlp_flash_model.mem[15'h0065], 14'h0abc);
    check(u_frlp_flash_model.mem[15'h006a], 14'h3fff);
    check(u_frlp_flash_model.mem[15'h007f], 14'h0155);
    check(u_frlp_flash_model.mem[15'h0080], 14'h3fff);
    check({busy, err, wdat}, {2'b00, 14'h3fff});
    @(posedge clock_i);
    slow <= 1'b0;
  endtask : t_commit
  task t_refuse();
    f0 = fires;
    set_ad(15'h0040, 14'h0000);
    key(8'h55);
    @(posedge clock_i);
    brk <= 1'b1;
    @(posedge clock_i);
    brk <= 1'b0;
    key(8'haa);
    pulse_start();
    check({err, 15'(fires - f0)}, 16'h8000);
    @(posedge clock_i);
    eclr <= 1'b1;
    wp <= 1'b1;
    @(posedge clock_i);
    eclr <= 1'b0;
    unlock();
    check({err, 15'(fires - f0)}, 16'h8000);
    check(u_frlp_flash_model.mem[15'h0040], 14'h3fff);
    @(posedge clock_i);
    eclr <= 1'b1;
    lo <= 1'b1;
    @(posedge clock_i);
    eclr <= 1'b0;
    unlock();
    check({err, 15'(fires - f0)}, 16'h0000);
    @(posedge clock_i);
    wp <= 1'b0;
    lo <= 1'b0;
  endtask : t_refuse
  task t_read(input logic [14:0] a, input logic c, input logic [13:0] exp);
    set_ad(a, 14'h0000);
    cfg <= c;
    @(posedge clock_i);
    rs <= 1'b1;
    @(posedge clock_i);
    rs <= 1'b0;
    wait_free();
    check(rdat, exp);
  endtask : t_read
  task t_erase();
    f0 = fires;
    @(posedge clock_i);
    ers <= 1'b1;
    set_ad(15'h0065, 14'h0000);
    unlock();
    check(fires - f0, 1);
    check(wdat, 14'h3fff);
    for (int i = 0; i < 32; i++)
      check(u_frlp_flash_model.mem[15'h0060 + i], 14'h3fff);
    @(posedge clock_i);
    ers <= 1'b0;
  endtask : t_erase
  // Main sequence
  initial
  begin
    {rst_n_i, en, lo, ers, st, rs, brk, eclr, kw, wp, slow, cfg} = '0;
    {kd, al, dl, ah, dh} = '0;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1;
    check({busy, stall, err, wdat}, {3'b000, 14'h3fff});
    t_commit();
    t_refuse();
    t_read(15'h0060, 1'b0, 14'h1234);
    t_read(15'h0065, 1'b1, 14'h0000);
    t_read(15'h0065, 1'b0, 14'h0abc);
    t_read(15'h1800, 1'b0, 14'h0000);
    t_erase();
    report_and_stop();
  end
endmodule : tb
